/* File: include/cpuex_pkg.sv */
// constants, types and helpers shared by the cpu exception end and the peripheral end
// assumes one clock domain at 40 MHz with a synchronous active-high reset
package cpuex_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_PULSE_NS = 400;
  localparam int RESET_PULSE_CYC_I = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RESET_PULSE_CYC = 8'(RESET_PULSE_CYC_I);

  // ----------------------------------------
  // vector numbers
  // ----------------------------------------
  localparam logic [7:0] VEC_RESET = 8'h00;
  localparam logic [7:0] VEC_BUS_ERR = 8'h02;
  localparam logic [7:0] VEC_ADDR_ERR = 8'h03;
  localparam logic [7:0] VEC_ILLEGAL = 8'h04;
  localparam logic [7:0] VEC_ZERO_DIV = 8'h05;
  localparam logic [7:0] VEC_BOUNDS = 8'h06;
  localparam logic [7:0] VEC_OVF_TRAP = 8'h07;
  localparam logic [7:0] VEC_PRIV = 8'h08;
  localparam logic [7:0] VEC_TRACE = 8'h09;
  localparam logic [7:0] VEC_LINE_A = 8'h0A;
  localparam logic [7:0] VEC_LINE_F = 8'h0B;
  localparam logic [7:0] VEC_UNINIT = 8'h0F;
  localparam logic [7:0] VEC_SPURIOUS = 8'h18;
  localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
  localparam logic [3:0] LINE_A_CODE = 4'hA;
  localparam logic [3:0] LINE_F_CODE = 4'hF;

  // ----------------------------------------
  // status word layout and bus codes
  // ----------------------------------------
  localparam int SR_T_BIT = 15;
  localparam int SR_S_BIT = 13;
  localparam int SR_MASK_LSB = 8;
  localparam logic [2:0] LVL_NONE = 3'h0;
  localparam logic [2:0] LVL_MAX = 3'h7;
  localparam logic [2:0] FC_INT_ACK = 3'h7;

  // ----------------------------------------
  // states and register images
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_RESET_VEC = 5'h02,
    ST_IACK_SETUP = 5'h04,
    ST_IACK_STROBE = 5'h08,
    ST_RESET_OUT = 5'h10
  } cpuex_state_e;

  typedef struct packed {
    cpuex_state_e st;
    logic s_bit;
    logic t_bit;
    logic [2:0] mask;
    logic t_start;
    logic trace_pend;
    logic boundary;
    logic [2:0] ipl_lvl;
    logic nmi_edge;
    logic [2:0] ack_lvl;
    logic [23:0] int_pc;
    logic exc_valid;
    logic [7:0] exc_vec;
    logic [23:0] exc_addr;
    logic exc_stack;
    logic [23:0] exc_pc;
    logic [15:0] exc_sr;
    logic go;
    logic ext_reset;
    logic [7:0] rst_cnt;
    logic [2:0] fc;
    logic [2:0] addr_lvl;
    logic rw;
    logic as_n;
    logic lds_n;
  } cpuex_core_s;

  localparam cpuex_core_s CORE_RST = '{
    st: ST_RESET_VEC, s_bit: 1'b1, t_bit: 1'b0, mask: LVL_MAX, t_start: 1'b0, trace_pend: 1'b0,
    boundary: 1'b0, ipl_lvl: LVL_NONE, nmi_edge: 1'b0, ack_lvl: LVL_NONE, int_pc: 24'h000000,
    exc_valid: 1'b0, exc_vec: 8'h00, exc_addr: 24'h000000, exc_stack: 1'b0, exc_pc: 24'h000000,
    exc_sr: 16'h0000, go: 1'b0, ext_reset: 1'b0, rst_cnt: 8'h00, fc: 3'h0, addr_lvl: 3'h0,
    rw: 1'b1, as_n: 1'b1, lds_n: 1'b1};

  typedef struct packed {
    logic [2:0] ipl_n;
    logic [7:0] data;
    logic transfer_acknowledge_n;
    logic vpa_n;
    logic berr_n;
    logic busy;
    logic acked;
  } cpuex_dev_s;

  localparam cpuex_dev_s DEV_RST = '{
    ipl_n: 3'h7, data: 8'h00, transfer_acknowledge_n: 1'b1, vpa_n: 1'b1, berr_n: 1'b1, busy: 1'b0, acked: 1'b0};

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [23:0] vec_addr(input logic [7:0] v);
    vec_addr = {14'h0000, v, 2'b00};
  endfunction

  function automatic logic [7:0] autovec(input logic [2:0] lvl);
    autovec = VEC_SPURIOUS + {5'h00, lvl};
  endfunction

endpackage

/* File: include/cpuex_if.sv */
// interrupt request and acknowledge wires between the processor and its peripherals
// assumes both ends share REF_CLK; all signals are driven from flip-flops
`timescale 1ns/1ps
interface cpuex_if;
  logic [2:0] ipl_n;
  logic [2:0] fc;
  logic [2:0] addr_lvl;
  logic rw;
  logic as_n;
  logic lds_n;
  logic [7:0] data;
  logic transfer_acknowledge_n;
  logic vpa_n;
  logic berr_n;

  modport cpu (
    input ipl_n,
    output fc,
    output addr_lvl,
    output rw,
    output as_n,
    output lds_n,
    input data,
    input transfer_acknowledge_n,
    input vpa_n,
    input berr_n
  );

  modport dev (
    output ipl_n,
    input fc,
    input addr_lvl,
    input rw,
    input as_n,
    input lds_n,
    output data,
    output transfer_acknowledge_n,
    output vpa_n,
    output berr_n
  );
endinterface

/* File: src/cpuex_core.sv */
// exception sequencer of the processor: reset, traps, interrupts, trace
// assumes an instruction pipeline on the user side and peripherals on the interface
//
// Functional notes
// RQ1 - group 1 at boundary, group 2 inside execution
// RQ2 - reset per clock, bus faults per bus cycle
// RQ3 - reset aborts, forces supervisor, clears trace
// RQ4 - reset sets priority mask to seven
// RQ5 - reset uses vector zero, stacks nothing
// RQ6 - reset loads stack pointer, then program counter
// RQ7 - reset instruction pulses external reset, continues
// RQ8 - levels one to seven, mask inhibits lower
// RQ9 - request pins active low, inverted internally
// RQ10 - requests pending, checked only between instructions
// RQ11 - interrupt copies status, supervisor, mask level
// RQ12 - acknowledge cycle: level, read, code, strobes
// RQ13 - peripheral returns vector with transfer acknowledge
// RQ14 - autovector built from acknowledged level
// RQ15 - unanswered acknowledge ends spurious via bus error
// RQ16 - stacked pc is next unexecuted instruction
// RQ17 - level seven edge-triggered and unmaskable
// RQ18 - uninitialised peripheral returns vector fifteen
// RQ19 - trap always, overflow and bounds conditional
// RQ20 - divide by zero raises zero-divide
// RQ21 - illegal words, line A and F vectors
// RQ22 - privileged instructions trap in user state
// RQ23 - vector address is number times four
// RQ24 - autovectors are numbers 25 to 31
`timescale 1ns/1ps
module cpuex_core (
  input wire logic REF_CLK,
  input wire logic RST,
  cpuex_if.cpu BUS,
  input wire logic INSN_END,
  input wire logic [15:0] NEXT_WORD,
  input wire logic NEXT_LEGAL,
  input wire logic NEXT_PRIV,
  input wire logic [23:0] NEXT_PC,
  input wire logic TRAP_STB,
  input wire logic [3:0] TRAP_NUM,
  input wire logic OVERFLOW_TRAP_STB,
  input wire logic OVERFLOW,
  input wire logic BOUNDS_CHECK_STB,
  input wire logic OUT_OF_BOUNDS,
  input wire logic SIGNED_DIVIDE_STB,
  input wire logic UNSIGNED_DIVIDE_STB,
  input wire logic [15:0] DIVISOR,
  input wire logic BUS_CYCLE_END,
  input wire logic BUS_ERR,
  input wire logic ADDR_ERR,
  input wire logic RESET_INSN_STB,
  input wire logic SR_WR,
  input wire logic [15:0] SR_WDATA,
  output logic GO,
  output logic BUSY,
  output logic EXC_VALID,
  output logic [7:0] EXC_VECTOR,
  output logic [23:0] EXC_ADDR,
  output logic EXC_STACK,
  output logic [23:0] EXC_PC,
  output logic [15:0] EXC_SR,
  output logic [15:0] SR_OUT,
  output logic EXT_RESET
);
  import cpuex_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] sr_word(input cpuex_core_s s);
    sr_word = 16'h0000;
    sr_word[SR_T_BIT] = s.t_bit;
    sr_word[SR_S_BIT] = s.s_bit;
    sr_word[SR_MASK_LSB +: 3] = s.mask;
  endfunction

  function automatic cpuex_core_s take_exc(input cpuex_core_s s, input logic [7:0] v, input logic stk,
                                           input logic [23:0] pc, input logic copy_sr);
    if (copy_sr) begin
      s.exc_sr = sr_word(s);
    end
    s.s_bit = 1'b1;
    s.t_bit = 1'b0;
    s.exc_valid = 1'b1;
    s.exc_vec = v;
    s.exc_addr = vec_addr(v); // RQ23
    s.exc_stack = stk;
    s.exc_pc = pc;
    return s;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  cpuex_core_s q;
  cpuex_core_s d;
  logic [2:0] req_lvl;
  logic rise7;
  logic int_due;

  assign req_lvl = ~BUS.ipl_n; // RQ9
  assign rise7 = (req_lvl == LVL_MAX) && (q.ipl_lvl != LVL_MAX); // RQ17
  assign int_due = (q.ipl_lvl != LVL_NONE) && (q.nmi_edge || (q.ipl_lvl > q.mask)); // RQ8 RQ17

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.exc_valid = 1'b0;
    d.go = 1'b0;
    d.ipl_lvl = req_lvl;
    if (rise7) begin
      d.nmi_edge = 1'b1; // RQ17
    end
    unique case (q.st)
      ST_RESET_VEC: begin
        d = take_exc(d, VEC_RESET, 1'b0, 24'h000000, 1'b1); // RQ5 RQ6
        d.st = ST_RUN;
        d.boundary = 1'b1;
      end
      ST_RUN: begin
        if (BUS_CYCLE_END && (ADDR_ERR || BUS_ERR)) begin
          d = take_exc(d, ADDR_ERR ? VEC_ADDR_ERR : VEC_BUS_ERR, 1'b1, NEXT_PC, 1'b1); // RQ2
          d.boundary = 1'b1;
          d.trace_pend = 1'b0;
        end else if (q.boundary) begin
          if (q.trace_pend) begin
            d = take_exc(d, VEC_TRACE, 1'b1, NEXT_PC, 1'b1); // RQ1
            d.trace_pend = 1'b0;
          end else if (int_due) begin
            d.exc_sr = sr_word(q); // RQ11
            d.s_bit = 1'b1;
            d.t_bit = 1'b0;
            d.mask = q.ipl_lvl;
            d.ack_lvl = q.ipl_lvl;
            d.int_pc = NEXT_PC; // RQ16
            if (q.ipl_lvl == LVL_MAX) begin
              d.nmi_edge = rise7;
            end
            d.addr_lvl = q.ipl_lvl; // RQ12
            d.rw = 1'b1;
            d.fc = FC_INT_ACK;
            d.st = ST_IACK_SETUP;
          end else if (!NEXT_LEGAL) begin
            if (NEXT_WORD[15:12] == LINE_A_CODE) begin
              d = take_exc(d, VEC_LINE_A, 1'b1, NEXT_PC, 1'b1); // RQ21
            end else if (NEXT_WORD[15:12] == LINE_F_CODE) begin
              d = take_exc(d, VEC_LINE_F, 1'b1, NEXT_PC, 1'b1); // RQ21
            end else begin
              d = take_exc(d, VEC_ILLEGAL, 1'b1, NEXT_PC, 1'b1); // RQ21
            end
          end else if (NEXT_PRIV && !q.s_bit) begin
            d = take_exc(d, VEC_PRIV, 1'b1, NEXT_PC, 1'b1); // RQ22
          end else begin
            d.go = 1'b1; // RQ10
            d.boundary = 1'b0;
            d.t_start = q.t_bit;
          end
        end else begin
          if (TRAP_STB) begin
            d = take_exc(d, VEC_TRAP_BASE + {4'h0, TRAP_NUM}, 1'b1, NEXT_PC, 1'b1); // RQ19 RQ1
          end else if (OVERFLOW_TRAP_STB && OVERFLOW) begin
            d = take_exc(d, VEC_OVF_TRAP, 1'b1, NEXT_PC, 1'b1); // RQ19
          end else if (BOUNDS_CHECK_STB && OUT_OF_BOUNDS) begin
            d = take_exc(d, VEC_BOUNDS, 1'b1, NEXT_PC, 1'b1); // RQ19
          end else if ((SIGNED_DIVIDE_STB || UNSIGNED_DIVIDE_STB) && (DIVISOR == 16'h0000)) begin
            d = take_exc(d, VEC_ZERO_DIV, 1'b1, NEXT_PC, 1'b1); // RQ20
          end else if (RESET_INSN_STB) begin
            d.ext_reset = 1'b1; // RQ7
            d.rst_cnt = RESET_PULSE_CYC - 8'h01;
            d.st = ST_RESET_OUT;
          end else if (SR_WR) begin
            d.t_bit = SR_WDATA[SR_T_BIT];
            d.s_bit = SR_WDATA[SR_S_BIT];
            d.mask = SR_WDATA[SR_MASK_LSB +: 3];
          end
          if (INSN_END) begin
            d.boundary = 1'b1;
            d.trace_pend = q.t_start;
          end
        end
      end
      ST_IACK_SETUP: begin
        d.as_n = 1'b0; // RQ12
        d.lds_n = 1'b0;
        d.st = ST_IACK_STROBE;
      end
      ST_IACK_STROBE: begin
        if (!BUS.transfer_acknowledge_n || !BUS.vpa_n || !BUS.berr_n) begin
          d.as_n = 1'b1; // RQ12
          d.lds_n = 1'b1;
          d.st = ST_RUN;
          if (!BUS.berr_n) begin
            d = take_exc(d, VEC_SPURIOUS, 1'b1, q.int_pc, 1'b0); // RQ15
          end else if (!BUS.vpa_n) begin
            d = take_exc(d, autovec(q.ack_lvl), 1'b1, q.int_pc, 1'b0); // RQ14 RQ24
          end else begin
            d = take_exc(d, BUS.data, 1'b1, q.int_pc, 1'b0); // RQ13
          end
        end
      end
      ST_RESET_OUT: begin
        if (q.rst_cnt == 8'h00) begin
          d.ext_reset = 1'b0; // RQ7
          d.st = ST_RUN;
        end else begin
          d.rst_cnt = q.rst_cnt - 8'h01;
        end
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      q <= CORE_RST; // RQ2 RQ3 RQ4
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign BUS.fc = q.fc;
  assign BUS.addr_lvl = q.addr_lvl;
  assign BUS.rw = q.rw;
  assign BUS.as_n = q.as_n;
  assign BUS.lds_n = q.lds_n;
  assign GO = q.go;
  assign BUSY = (q.st != ST_RUN);
  assign EXC_VALID = q.exc_valid;
  assign EXC_VECTOR = q.exc_vec;
  assign EXC_ADDR = q.exc_addr;
  assign EXC_STACK = q.exc_stack;
  assign EXC_PC = q.exc_pc;
  assign EXC_SR = q.exc_sr;
  assign SR_OUT = sr_word(q);
  assign EXT_RESET = q.ext_reset;
endmodule

/* File: src/cpuex_periph.sv */
// interrupting peripheral and acknowledge bus logic
// assumes the processor end on the interface and a user that sets level and vector
`timescale 1ns/1ps
module cpuex_periph (
  input wire logic REF_CLK,
  input wire logic RST,
  cpuex_if.dev BUS,
  input wire logic [2:0] REQ_LEVEL,
  input wire logic [7:0] VEC_NUM,
  input wire logic VEC_INIT,
  input wire logic AUTOVEC,
  output logic ACKED
);
  import cpuex_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  cpuex_dev_s q;
  cpuex_dev_s d;
  logic iack_seen;

  assign iack_seen = !BUS.as_n && !BUS.lds_n && BUS.rw && (BUS.fc == FC_INT_ACK);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.acked = 1'b0;
    d.ipl_n = ~REQ_LEVEL; // RQ9
    if (BUS.as_n) begin
      d.busy = 1'b0;
      d.transfer_acknowledge_n = 1'b1;
      d.vpa_n = 1'b1;
      d.berr_n = 1'b1;
    end else if (iack_seen && !q.busy) begin
      d.busy = 1'b1;
      if ((BUS.addr_lvl == REQ_LEVEL) && (REQ_LEVEL != LVL_NONE)) begin
        d.acked = 1'b1;
        if (AUTOVEC) begin
          d.vpa_n = 1'b0;
        end else begin
          d.data = VEC_INIT ? VEC_NUM : VEC_UNINIT; // RQ13 RQ18
          d.transfer_acknowledge_n = 1'b0;
        end
      end else begin
        d.berr_n = 1'b0; // RQ15
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign BUS.ipl_n = q.ipl_n;
  assign BUS.data = q.data;
  assign BUS.transfer_acknowledge_n = q.transfer_acknowledge_n;
  assign BUS.vpa_n = q.vpa_n;
  assign BUS.berr_n = q.berr_n;
  assign ACKED = q.acked;
endmodule

/* File: verification/cpuex_properties.sv */
// link checker for the acknowledge wires
// assumes the bench clock and synchronous active-high reset
`timescale 1ns/1ps
module cpuex_properties
  import cpuex_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [2:0] fc,
  input wire logic [2:0] addr_lvl,
  input wire logic rw,
  input wire logic as_n,
  input wire logic lds_n,
  input wire logic [7:0] data,
  input wire logic transfer_acknowledge_n,
  input wire logic vpa_n,
  input wire logic berr_n
);
  // ----
  // link rules
  // ----
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  property p_idle;
    $fell(RST) |-> as_n && lds_n && rw && transfer_acknowledge_n && vpa_n && berr_n;
  endproperty
  a_idle: assert property (p_idle) else $error("link busy after reset");
  property p_setup;
    $fell(as_n) |-> fc == FC_INT_ACK && rw && $stable(fc) && $stable(addr_lvl);
  endproperty
  a_setup: assert property (p_setup) else $error("strobe before setup");
  property p_pair;
    as_n == lds_n;
  endproperty
  a_pair: assert property (p_pair) else $error("strobes apart");
  property p_level;
    $fell(as_n) |-> addr_lvl != LVL_NONE;
  endproperty
  a_level: assert property (p_level) else $error("level zero acknowledged");
  property p_answer;
    $fell(as_n) |-> ##1 (!transfer_acknowledge_n || !vpa_n || !berr_n);
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_release;
    $fell(as_n) |-> ##1 !as_n ##1 (as_n && lds_n);
  endproperty
  a_release: assert property (p_release) else $error("strobes not negated");
  property p_hold;
    $rose(as_n) |-> !(transfer_acknowledge_n && vpa_n && berr_n) ##1 (transfer_acknowledge_n && vpa_n && berr_n);
  endproperty
  a_hold: assert property (p_hold) else $error("answer not held or released");
  property p_data;
    !transfer_acknowledge_n && !$past(transfer_acknowledge_n) |-> $stable(data);
  endproperty
  a_data: assert property (p_data) else $error("vector moved");
  property p_gate;
    $fell(transfer_acknowledge_n) |-> !as_n && fc == FC_INT_ACK;
  endproperty
  a_gate: assert property (p_gate) else $error("answer without strobe");
endmodule

/* File: verification/tb.sv */
// bench joining the exception end and the peripheral end
// assumes package, interface and both design modules compiled first
`timescale 1ns/1ps
module tb;
  import cpuex_pkg::*;
  // ----
  // signals and instances
  // ----
  logic REF_CLK, RST, insn_end, next_legal, next_priv, trap_stb, ovf_stb, ovf, bnd_stb, oob, sdiv_stb;
  logic udiv_stb, bus_end, bus_err, addr_err, rst_insn, sr_wr, vec_init, autovec, spur_arm;
  logic go, busy, exc_valid, exc_stack, ext_reset, acked;
  logic [15:0] next_word, divisor, sr_wdata, sr_out, exc_sr;
  logic [23:0] next_pc, exc_pc, exc_addr;
  logic [7:0] vec_num, exc_vector;
  logic [3:0] trap_num;
  logic [2:0] req_level;
  logic [48:0] exq[$];
  int errors, tests_run, cycles, ext_cnt, ack_cnt;
  int tcode[11] = '{1, 2, 2, 3, 3, 4, 4, 5, 5, 6, 7};
  logic [15:0] targ[11] = '{16'h3, 16'h1, 16'h0, 16'h1, 16'h0, 16'h0, 16'h1, 16'h0, 16'hFF, 16'h0, 16'h0};
  logic [8:0] texp[11] = '{9'h123, 9'h107, 9'h0, 9'h106, 9'h0, 9'h105, 9'h0, 9'h105, 9'h0, 9'h102, 9'h103};
  logic [15:0] iw[3] = '{16'h4AFC, 16'hA123, 16'hF456};
  logic [7:0] iv[3] = '{VEC_ILLEGAL, VEC_LINE_A, VEC_LINE_F};
  cpuex_if u_cpuex_if ();
  cpuex_core u_cpuex_core (.REF_CLK(REF_CLK), .RST(RST), .BUS(u_cpuex_if), .INSN_END(insn_end),
    .NEXT_WORD(next_word), .NEXT_LEGAL(next_legal), .NEXT_PRIV(next_priv), .NEXT_PC(next_pc),
    .TRAP_STB(trap_stb), .TRAP_NUM(trap_num), .OVERFLOW_TRAP_STB(ovf_stb), .OVERFLOW(ovf),
    .BOUNDS_CHECK_STB(bnd_stb), .OUT_OF_BOUNDS(oob), .SIGNED_DIVIDE_STB(sdiv_stb),
    .UNSIGNED_DIVIDE_STB(udiv_stb), .DIVISOR(divisor), .BUS_CYCLE_END(bus_end), .BUS_ERR(bus_err),
    .ADDR_ERR(addr_err), .RESET_INSN_STB(rst_insn), .SR_WR(sr_wr), .SR_WDATA(sr_wdata), .GO(go),
    .BUSY(busy), .EXC_VALID(exc_valid), .EXC_VECTOR(exc_vector), .EXC_ADDR(exc_addr),
    .EXC_STACK(exc_stack), .EXC_PC(exc_pc), .EXC_SR(exc_sr), .SR_OUT(sr_out), .EXT_RESET(ext_reset));
  cpuex_periph u_cpuex_periph (.REF_CLK(REF_CLK), .RST(RST), .BUS(u_cpuex_if), .REQ_LEVEL(req_level),
    .VEC_NUM(vec_num), .VEC_INIT(vec_init), .AUTOVEC(autovec), .ACKED(acked));
  cpuex_properties u_cpuex_properties (.REF_CLK(REF_CLK), .RST(RST), .fc(u_cpuex_if.fc),
    .addr_lvl(u_cpuex_if.addr_lvl), .rw(u_cpuex_if.rw), .as_n(u_cpuex_if.as_n), .lds_n(u_cpuex_if.lds_n),
    .data(u_cpuex_if.data), .transfer_acknowledge_n(u_cpuex_if.transfer_acknowledge_n), .vpa_n(u_cpuex_if.vpa_n),
    .berr_n(u_cpuex_if.berr_n));
  // ----
  // tasks
  // ----
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wait_go();
    int n;
    n = 0;
    while (go !== 1'b1 && n < 300) begin
      @(negedge REF_CLK);
      n++;
    end
    check("go", 32'(n < 300), 32'h1);
    @(negedge REF_CLK);
  endtask
  task automatic insn(input int code, input logic [15:0] arg);
    int n;
    case (code)
      1: {trap_stb, trap_num} = {1'b1, arg[3:0]};
      2: {ovf_stb, ovf} = {1'b1, arg[0]};
      3: {bnd_stb, oob} = {1'b1, arg[0]};
      4: {sdiv_stb, divisor} = {1'b1, arg};
      5: {udiv_stb, divisor} = {1'b1, arg};
      6: {bus_end, bus_err} = 2'h3;
      7: {bus_end, addr_err} = 2'h3;
      8: rst_insn = 1'b1;
      9: {sr_wr, sr_wdata} = {1'b1, arg};
      default: ;
    endcase
    @(negedge REF_CLK);
    {trap_stb, ovf_stb, bnd_stb, sdiv_stb, udiv_stb, bus_end, bus_err, addr_err, rst_insn, sr_wr} = 10'h0;
    if (code == 6 || code == 7) begin
      wait_go();
      return;
    end
    repeat (2) @(negedge REF_CLK);
    n = 0;
    while (busy === 1'b1 && n < 100) begin
      @(negedge REF_CLK);
      n++;
    end
    if (code < 6 || code > 7) begin
      insn_end = 1'b1;
      @(negedge REF_CLK);
      insn_end = 1'b0;
    end
    wait_go();
  endtask
  task automatic chk_exc(input logic [7:0] vec, input logic irq, input logic [15:0] sr);
    logic [48:0] e;
    if (exq.size() == 0) begin
      check("exception", 32'h0, 32'h1);
      return;
    end
    e = exq.pop_front();
    check("vector", 32'(e[7:0]), 32'(vec));
    check("stacking", 32'(e[48]), 32'(vec != 8'h00));
    if (irq === 1'b1) begin
      check("stacked pc", 32'(e[31:8]), 32'(next_pc));
      check("status copy", 32'(e[47:32]), 32'(sr));
    end
  endtask
  task automatic no_exc();
    check("no exception", 32'(exq.size()), 32'h0);
  endtask
  task automatic do_reset();
    RST = 1'b1;
    exq.delete();
    repeat (3) @(negedge REF_CLK);
    check("reset status", 32'(sr_out), 32'h2700);
    RST = 1'b0;
    wait_go();
    chk_exc(8'h00, 1'b0, 16'h0);
  endtask
  // ----
  // clock and monitors
  // ----
  initial begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end
  always @(negedge REF_CLK) begin
    cycles++;
    if (acked === 1'b1) ack_cnt++;
    if (exc_valid === 1'b1) begin
      exq.push_back({exc_stack, exc_sr, exc_pc, exc_vector});
      check("vector address", 32'(exc_addr), {22'h0, exc_vector, 2'b00});
    end
    if (ext_reset === 1'b1) ext_cnt++;
    if (u_cpuex_if.as_n === 1'b0) check("ack code", 32'(u_cpuex_if.fc), 32'(FC_INT_ACK));
    if (cycles > 20000) begin
      errors++;
      summarize();
    end
  end
  always @(negedge REF_CLK) begin
    if (exc_valid === 1'b1) {next_legal, next_priv, next_word} = {2'b10, 16'h4E71};
    if (spur_arm === 1'b1 && u_cpuex_if.as_n === 1'b0) {req_level, spur_arm} = 4'h0;
  end
  // ----
  // sequence
  // ----
  initial begin
    {insn_end, next_priv, trap_stb, ovf_stb, ovf, bnd_stb, oob, sdiv_stb, udiv_stb} = 9'h0;
    {bus_end, bus_err, addr_err, rst_insn, sr_wr, autovec, spur_arm} = 7'h0;
    {divisor, sr_wdata, trap_num, req_level} = 39'h0;
    {next_legal, vec_init, next_word, next_pc, vec_num} = {2'b11, 16'h4E71, 24'h001234, 8'h40};
    do_reset();
    for (int i = 0; i < 11; i++) begin
      insn(tcode[i], targ[i]);
      if (texp[i][8] === 1'b1) chk_exc(texp[i][7:0], 1'b0, 16'h0);
      else no_exc();
    end
    for (int i = 0; i < 3; i++) begin
      {next_legal, next_word} = {1'b0, iw[i]};
      insn(0, 16'h0);
      chk_exc(iv[i], 1'b0, 16'h0);
    end
    insn(9, 16'h0000);
    next_priv = 1'b1;
    insn(0, 16'h0);
    chk_exc(VEC_PRIV, 1'b0, 16'h0);
    check("supervisor", 32'(sr_out[13]), 32'h1);
    insn(9, 16'h2300);
    req_level = 3'h2;
    insn(0, 16'h0);
    check("request pins", 32'(u_cpuex_if.ipl_n), 32'h5);
    no_exc();
    req_level = 3'h5;
    insn(0, 16'h0);
    chk_exc(8'h40, 1'b1, 16'h2300);
    check("mask", 32'(sr_out[10:8]), 32'h5);
    req_level = 3'h0;
    autovec = 1'b1;
    for (int l = 1; l < 7; l++) begin
      insn(9, 16'h2000);
      req_level = 3'(l);
      insn(0, 16'h0);
      chk_exc(8'(24 + l), 1'b1, 16'h2000);
      req_level = 3'h0;
    end
    {autovec, vec_init} = 2'b00;
    insn(9, 16'h2000);
    req_level = 3'h3;
    insn(0, 16'h0);
    chk_exc(VEC_UNINIT, 1'b1, 16'h2000);
    {vec_init, req_level} = 4'h8;
    insn(9, 16'h2000);
    {spur_arm, req_level} = 4'hE;
    insn(0, 16'h0);
    chk_exc(VEC_SPURIOUS, 1'b1, 16'h2000);
    autovec = 1'b1;
    insn(9, 16'h2700);
    req_level = 3'h7;
    insn(0, 16'h0);
    chk_exc(8'h1F, 1'b1, 16'h2700);
    insn(0, 16'h0);
    no_exc();
    insn(9, 16'h2600);
    chk_exc(8'h1F, 1'b1, 16'h2600);
    {autovec, req_level} = 4'h0;
    insn(9, 16'hA700);
    insn(1, 16'h0001);
    chk_exc(8'h21, 1'b0, 16'h0);
    chk_exc(VEC_TRACE, 1'b0, 16'h0);
    insn(0, 16'h0);
    no_exc();
    ext_cnt = 0;
    insn(8, 16'h0);
    check("reset pulse", 32'(ext_cnt), 32'(RESET_PULSE_CYC));
    no_exc();
    insn(9, 16'h8000);
    do_reset();
    no_exc();
    check("acks", 32'(ack_cnt), 32'hA);
    summarize();
  end
endmodule
